// ### core/capture_edge_sync.sv
// input pin synchroniser and polarity-selected edge detector for one capture channel
`timescale 1ns/1ps
`default_nettype none
module capture_edge_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // pin and polarity
    input wire logic pinIn,
    input wire logic fallingEdge,
    // detected edge
    output logic edgePulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic rising;
    logic falling;

    // two stages before any logic looks at the pin
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rising = sync_q & ~prev_q;
    assign falling = ~sync_q & prev_q;
    assign edgePulse = fallingEdge ? falling : rising;
endmodule
`default_nettype wire

// ### core/tevt_pkg.sv
// constants, register map and carrier types for the timer event generation block
package tevt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int NCH = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h10;
    localparam logic [ADDR_W-1:0] EVTGEN_OFFSET = 8'h14;
    localparam logic [ADDR_W-1:0] CFG_PRELOAD_OFFSET = 8'h20;
    localparam logic [ADDR_W-1:0] CFG_ACTIVE_OFFSET = 8'h24;
    localparam logic [ADDR_W-1:0] COMPARE_BASE = 8'h34;
    localparam logic [ADDR_W-1:0] COMPARE_STRIDE = 8'h04;

    // event generation register fields
    localparam int EVT_W = 8;
    localparam int EVT_UPDATE_BIT = 0;
    localparam int EVT_CHAN_BIT = 1;
    localparam int EVT_COMM_BIT = 5;
    localparam int EVT_TRIG_BIT = 6;
    localparam int EVT_BREAK_BIT = 7;
    localparam logic [15:0] EVTGEN_RESET = 16'h0000;

    // control register: fields of ctrl_t in bits 13:0, output enable above
    localparam int CTRL_W = 14;
    localparam int MOE_BIT = 14;
    localparam int STATUS_W = 11;
    localparam int CFG_W = 20;

    // channels that own complementary outputs
    localparam logic [NCH-1:0] COMPL_CHANNELS = 4'h7;

    typedef struct packed {
        logic [NCH-1:0] capturePolarity;
        logic [NCH-1:0] chanIsInput;
        logic chanControlPreload;
        logic updateRequestSource;
        logic updateDisable;
        logic countDown;
        logic [1:0] centerAlignSelect;
    } ctrl_t;

    typedef struct packed {
        logic [NCH-1:0] chanOvercaptureFlag;
        logic breakFlag;
        logic triggerFlag;
        logic [NCH-1:0] chanEventFlag;
        logic updateFlag;
    } status_t;

    typedef struct packed {
        logic [NCH-1:0][2:0] outputCompareMode;
        logic [NCH-1:0] complementaryOutputEnable;
        logic [NCH-1:0] channelOutputEnable;
    } chan_cfg_t;

    localparam ctrl_t CTRL_RESET = '0;
    localparam status_t STATUS_RESET = '0;
    localparam chan_cfg_t CFG_RESET = '0;
endpackage

// ### core/timer_event_generation.sv
// timer software event generation, channel and update status flags, capture registers
//
// Notes on behaviour
// - output channel, edge-aligned: flag set when counter equals compare value
// - compare above reload: flag on overflow (up, centre) or underflow (down)
// - input channel: flag set when a selected-polarity edge captures the counter
// - input mode: flag cleared by software write or by reading capture register
// - update flag bit 0 set at repetition zero unless updates disabled; software clears
// - software update sets update flag only with update disable and source zero
// - trigger reinitialisation sets update flag with update disable and source zero
// - bit 7 raises break: output enable cleared, break flag set, self-clears
// - bit 6 raises trigger: trigger flag set, bit self-clears
// - bit 5 commutation transfers complementary channel config when preload on
// - bit 1 raises channel 1 event, self-clears; output mode sets flag
// - software event in input mode captures counter and sets channel flag
// - capture while channel flag already set also sets overcapture flag
// - bit 0 update reinitialises counter: zero, or reload when counting down
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module timer_event_generation (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [tevt_pkg::ADDR_W-1:0] regAddr,
    input wire logic [tevt_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [tevt_pkg::DATA_W-1:0] regRdata,
    // counter core
    input wire logic [tevt_pkg::CNT_W-1:0] counterValue,
    input wire logic [tevt_pkg::CNT_W-1:0] autoReloadValue,
    input wire logic counterOverflow,
    input wire logic counterUnderflow,
    input wire logic repetitionZero,
    input wire logic triggerReinit,
    // channel input pins
    input wire logic [tevt_pkg::NCH-1:0] chanInputSignal,
    // counter control
    output logic counterReinit,
    output logic [tevt_pkg::CNT_W-1:0] counterReinitValue,
    output logic prescalerClear,
    // event strobes
    output logic updateEvent,
    output logic triggerEvent,
    output logic breakEvent,
    output logic commutationEvent,
    // output stage and flags
    output logic mainOutputEnable,
    output tevt_pkg::chan_cfg_t activeChanConfig,
    output tevt_pkg::status_t statusFlags
);
    localparam int NCH = tevt_pkg::NCH;
    localparam int CNT_W = tevt_pkg::CNT_W;
    localparam int DATA_W = tevt_pkg::DATA_W;
    localparam int STATUS_W = tevt_pkg::STATUS_W;

    function automatic logic [tevt_pkg::ADDR_W-1:0] compareOffset(input int idx);
        return tevt_pkg::COMPARE_BASE + tevt_pkg::ADDR_W'(idx) * tevt_pkg::COMPARE_STRIDE;
    endfunction

    // register state
    tevt_pkg::ctrl_t ctrl_q;
    logic moe_q;
    logic moe_d;
    tevt_pkg::status_t status_q;
    logic [STATUS_W-1:0] status_d;
    tevt_pkg::chan_cfg_t cfgPreload_q;
    tevt_pkg::chan_cfg_t cfgActive_q;
    tevt_pkg::chan_cfg_t cfgActive_d;
    logic [tevt_pkg::EVT_W-1:0] evtPulse_q;
    logic [CNT_W-1:0] compare_q [NCH];
    logic [NCH-1:0] match_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdMux;

    // output registers
    logic counterReinit_q;
    logic [CNT_W-1:0] reinitValue_q;
    logic prescalerClear_q;
    logic updateEvent_q;
    logic triggerEvent_q;
    logic breakEvent_q;
    logic commEvent_q;

    // address decode
    logic wrCtrl;
    logic wrStatus;
    logic wrEvtgen;
    logic wrCfg;
    assign wrCtrl = regWrite && (regAddr == tevt_pkg::CTRL_OFFSET);
    assign wrStatus = regWrite && (regAddr == tevt_pkg::STATUS_OFFSET);
    assign wrEvtgen = regWrite && (regAddr == tevt_pkg::EVTGEN_OFFSET);
    assign wrCfg = regWrite && (regAddr == tevt_pkg::CFG_PRELOAD_OFFSET);

    // software events, each alive for exactly one cycle after the write
    logic swUpdate;
    logic [NCH-1:0] swChan;
    logic swComm;
    logic swTrig;
    logic swBreak;
    assign swUpdate = evtPulse_q[tevt_pkg::EVT_UPDATE_BIT];
    assign swChan = evtPulse_q[tevt_pkg::EVT_CHAN_BIT +: NCH];
    assign swComm = evtPulse_q[tevt_pkg::EVT_COMM_BIT];
    assign swTrig = evtPulse_q[tevt_pkg::EVT_TRIG_BIT];
    assign swBreak = evtPulse_q[tevt_pkg::EVT_BREAK_BIT];

    // counting mode
    logic centerMode;
    logic downMode;
    logic updateAllowed;
    logic sourceAllowed;
    logic beyondEdge;
    assign centerMode = (ctrl_q.centerAlignSelect != 2'h0);
    assign downMode = ctrl_q.countDown && !centerMode;
    assign updateAllowed = !ctrl_q.updateDisable;
    assign sourceAllowed = updateAllowed && !ctrl_q.updateRequestSource;
    assign beyondEdge = (counterOverflow && !downMode) || (counterUnderflow && downMode);

    // update flag sources
    logic updateSet;
    logic updateHappens;
    assign updateSet = (repetitionZero && updateAllowed)
        || (swUpdate && sourceAllowed)
        || (triggerReinit && sourceAllowed);
    assign updateHappens = updateAllowed && (repetitionZero || swUpdate || triggerReinit);

    // per-channel capture and compare
    logic [NCH-1:0] hwEdge;
    logic [NCH-1:0] matchNow;
    logic [NCH-1:0] beyondHit;
    logic [NCH-1:0] capture;
    logic [NCH-1:0] chanSet;
    logic [NCH-1:0] ovcSet;
    logic [NCH-1:0] wrCmp;
    logic [NCH-1:0] rdCmpClr;
    logic [NCH-1:0] take;

    generate
        for (genvar i = 0; i < NCH; i++)
        begin : g_chan
            logic [CNT_W-1:0] cmpNext;

            capture_edge_sync u_sync (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .pinIn(chanInputSignal[i]),
                .fallingEdge(ctrl_q.capturePolarity[i]),
                .edgePulse(hwEdge[i])
            );

            // centre-aligned counting never flags an equality
            assign matchNow[i] = !ctrl_q.chanIsInput[i] && !centerMode
                && (counterValue == compare_q[i]);
            // compare above reload can never match, so the wrap stands in
            assign beyondHit[i] = !ctrl_q.chanIsInput[i]
                && (compare_q[i] > autoReloadValue) && beyondEdge;
            assign capture[i] = ctrl_q.chanIsInput[i] && (hwEdge[i] || swChan[i]);
            assign chanSet[i] = capture[i] || (!ctrl_q.chanIsInput[i]
                && (swChan[i] || (matchNow[i] && !match_q[i]) || beyondHit[i]));
            assign ovcSet[i] = capture[i] && status_q.chanEventFlag[i];
            assign wrCmp[i] = regWrite && (regAddr == compareOffset(i))
                && !ctrl_q.chanIsInput[i];
            assign rdCmpClr[i] = regRead && (regAddr == compareOffset(i))
                && ctrl_q.chanIsInput[i];
            // capture beats software; input-mode writes are dropped
            assign cmpNext = capture[i] ? counterValue
                : (wrCmp[i] ? regWdata[CNT_W-1:0] : compare_q[i]);
            // channels without complementary outputs never wait for commutation
            assign take[i] = !tevt_pkg::COMPL_CHANNELS[i]
                || !ctrl_q.chanControlPreload || swComm;

            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    compare_q[i] <= '0;
                end
                else
                begin
                    compare_q[i] <= cmpNext;
                end
            end
        end
    endgenerate

    // status flags: set wins over any clear in the same cycle
    logic [STATUS_W-1:0] statusSet;
    logic [STATUS_W-1:0] statusClr;
    assign statusSet = {ovcSet, swBreak, swTrig, chanSet, updateSet};
    assign statusClr = (wrStatus ? ~regWdata[STATUS_W-1:0] : '0)
        | {6'h00, rdCmpClr, 1'b0};
    assign status_d = (status_q & ~statusClr) | statusSet;

    // break clears the output enable even against a software set
    assign moe_d = swBreak ? 1'b0 : (wrCtrl ? regWdata[tevt_pkg::MOE_BIT] : moe_q);

    // configuration transfer to the active copy
    always_comb
    begin
        cfgActive_d = cfgActive_q;
        for (int k = 0; k < NCH; k++)
        begin
            if (take[k])
            begin
                cfgActive_d.channelOutputEnable[k] = cfgPreload_q.channelOutputEnable[k];
                cfgActive_d.complementaryOutputEnable[k] =
                    cfgPreload_q.complementaryOutputEnable[k];
                cfgActive_d.outputCompareMode[k] = cfgPreload_q.outputCompareMode[k];
            end
        end
    end

    // read selection; event generation and unmapped offsets read zero
    always_comb
    begin
        rdMux = '0;
        if (regAddr == tevt_pkg::CTRL_OFFSET)
        begin
            rdMux = {17'h00000, moe_q, ctrl_q};
        end
        else if (regAddr == tevt_pkg::STATUS_OFFSET)
        begin
            rdMux = {21'h000000, status_q};
        end
        else if (regAddr == tevt_pkg::CFG_PRELOAD_OFFSET)
        begin
            rdMux = {12'h000, cfgPreload_q};
        end
        else if (regAddr == tevt_pkg::CFG_ACTIVE_OFFSET)
        begin
            rdMux = {12'h000, cfgActive_q};
        end
        else
        begin
            for (int k = 0; k < NCH; k++)
            begin
                if (regAddr == compareOffset(k))
                begin
                    rdMux = {16'h0000, compare_q[k]};
                end
            end
        end
    end

    // control and configuration registers
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= tevt_pkg::CTRL_RESET;
            cfgPreload_q <= tevt_pkg::CFG_RESET;
            cfgActive_q <= tevt_pkg::CFG_RESET;
            moe_q <= 1'b0;
        end
        else
        begin
            if (wrCtrl)
            begin
                ctrl_q <= tevt_pkg::ctrl_t'(regWdata[tevt_pkg::CTRL_W-1:0]);
            end
            if (wrCfg)
            begin
                cfgPreload_q <= tevt_pkg::chan_cfg_t'(regWdata[tevt_pkg::CFG_W-1:0]);
            end
            cfgActive_q <= cfgActive_d;
            moe_q <= moe_d;
        end
    end

    // event generation: a one holds for one cycle, a zero does nothing
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            evtPulse_q <= tevt_pkg::EVTGEN_RESET[tevt_pkg::EVT_W-1:0];
        end
        else if (wrEvtgen)
        begin
            evtPulse_q <= regWdata[tevt_pkg::EVT_W-1:0];
        end
        else
        begin
            evtPulse_q <= '0;
        end
    end

    // flags, match history and read data
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_q <= tevt_pkg::STATUS_RESET;
            // counter and compare both sit at zero out of reset: no false match flag
            match_q <= '1;
            rdata_q <= '0;
        end
        else
        begin
            status_q <= tevt_pkg::status_t'(status_d);
            match_q <= matchNow;
            rdata_q <= regRead ? rdMux : '0;
        end
    end

    // event strobes and counter reinitialisation
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            counterReinit_q <= 1'b0;
            reinitValue_q <= '0;
            prescalerClear_q <= 1'b0;
            updateEvent_q <= 1'b0;
            triggerEvent_q <= 1'b0;
            breakEvent_q <= 1'b0;
            commEvent_q <= 1'b0;
        end
        else
        begin
            counterReinit_q <= swUpdate;
            prescalerClear_q <= swUpdate;
            if (swUpdate)
            begin
                reinitValue_q <= downMode ? autoReloadValue : '0;
            end
            updateEvent_q <= updateHappens;
            triggerEvent_q <= swTrig;
            breakEvent_q <= swBreak;
            commEvent_q <= swComm;
        end
    end

    assign regRdata = rdata_q;
    assign counterReinit = counterReinit_q;
    assign counterReinitValue = reinitValue_q;
    assign prescalerClear = prescalerClear_q;
    assign updateEvent = updateEvent_q;
    assign triggerEvent = triggerEvent_q;
    assign breakEvent = breakEvent_q;
    assign commutationEvent = commEvent_q;
    assign mainOutputEnable = moe_q;
    assign activeChanConfig = cfgActive_q;
    assign statusFlags = status_q;
endmodule
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the timer event generation block
`timescale 1ns/1ps
`default_nettype none
bind timer_event_generation timer_event_generation_checker chkInst (.ref_clk, .resetn, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .counterReinit, .prescalerClear, .updateEvent,
    .triggerEvent, .breakEvent, .commutationEvent, .mainOutputEnable, .statusFlags);
module tb;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdata;
    logic [15:0] counterValue = 16'h0000;
    logic [15:0] autoReloadValue = 16'h1234;
    logic counterOverflow = 1'b0;
    logic counterUnderflow = 1'b0;
    logic repetitionZero = 1'b0;
    logic triggerReinit = 1'b0;
    logic [3:0] chanInputSignal = 4'h0;
    logic counterReinit, prescalerClear, updateEvent, triggerEvent, breakEvent;
    logic commutationEvent, mainOutputEnable;
    logic [15:0] counterReinitValue;
    tevt_pkg::chan_cfg_t activeChanConfig;
    tevt_pkg::status_t statusFlags;
    logic [7:0] c;
    int failCount = 0;
    int nCompared = 0;

    timer_event_generation uut (.ref_clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead,
        .regRdata, .counterValue, .autoReloadValue, .counterOverflow, .counterUnderflow,
        .repetitionZero, .triggerReinit, .chanInputSignal, .counterReinit, .counterReinitValue,
        .prescalerClear, .updateEvent, .triggerEvent, .breakEvent, .commutationEvent,
        .mainOutputEnable, .activeChanConfig, .statusFlags);

    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp)
        begin
            failCount++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        chk(regRdata, exp);
    endtask

    // software event: strobes stand two cycles after the write cycle
    task automatic ev(input logic [31:0] d);
        wr(tevt_pkg::EVTGEN_OFFSET, d);
        @(posedge ref_clk);
        #1;
    endtask

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // watchdog so a stuck run still reports
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        failCount++;
        conclude();
    end

    initial
    begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        settle();
        chk(32'(statusFlags), 32'h0);
        rd(tevt_pkg::STATUS_OFFSET, 32'h0);
        rd(tevt_pkg::EVTGEN_OFFSET, 32'h0);
        rd(8'h08, 32'h0);
        // up, down, centre, update disabled, update source set
        for (int i = 0; i < 5; i++)
        begin
            c = (i == 0) ? 8'h00 : ((i == 1) ? 8'h04 : ((i == 2) ? 8'h01 : (8'h01 << i)));
            wr(tevt_pkg::CTRL_OFFSET, {24'h0, c});
            ev(32'h00000001);
            chk(32'(counterReinit & prescalerClear), 32'h1);
            chk(32'(counterReinitValue), (c == 8'h04) ? 32'(autoReloadValue) : 32'h0);
            // source select blocks only the flag; the update itself still happens
            chk(32'({statusFlags.updateFlag, updateEvent}), c[3] ? 32'h0 : (c[4] ? 32'h1 : 32'h3));
            wr(tevt_pkg::STATUS_OFFSET, 32'h0);
            settle();
            chk(32'(statusFlags.updateFlag), 32'h0);
        end
        ev(32'h00000000);
        chk(32'({counterReinit, triggerEvent, breakEvent, commutationEvent}), 32'h0);
        ev(32'h00000040);
        chk(32'({triggerEvent, statusFlags.triggerFlag}), 32'h3);
        @(posedge ref_clk);
        #1;
        chk(32'(triggerEvent), 32'h0);
        wr(tevt_pkg::CTRL_OFFSET, 32'h00004000);
        settle();
        chk(32'(mainOutputEnable), 32'h1);
        ev(32'h00000080);
        chk(32'({breakEvent, statusFlags.breakFlag, mainOutputEnable}), 32'h6);
        // preload holds channels 1-3 back until commutation; channel 4 is direct
        wr(tevt_pkg::CTRL_OFFSET, 32'h00000020);
        wr(tevt_pkg::CFG_PRELOAD_OFFSET, 32'h000000FF);
        settle();
        chk(32'(activeChanConfig), 32'h00000088);
        ev(32'h00000020);
        chk(32'(commutationEvent), 32'h1);
        settle();
        chk(32'(activeChanConfig), 32'h000000FF);
        wr(tevt_pkg::STATUS_OFFSET, 32'h0);
        for (int ch = 0; ch < 4; ch++)
        begin
            ev(32'h2 << ch);
            chk(32'(statusFlags.chanEventFlag), (32'h2 << ch) - 32'h1);
        end
        chk(32'(statusFlags.chanOvercaptureFlag), 32'h0);
        wr(tevt_pkg::STATUS_OFFSET, 32'h0);
        wr(tevt_pkg::COMPARE_BASE, 32'h00000010);
        wr(tevt_pkg::COMPARE_BASE + tevt_pkg::COMPARE_STRIDE, 32'h00002000);
        @(posedge ref_clk);
        counterValue <= 16'h0010;
        settle();
        chk(32'(statusFlags.chanEventFlag), 32'h1);
        @(posedge ref_clk);
        counterValue <= 16'h0011;
        counterOverflow <= 1'b1;
        @(posedge ref_clk);
        counterOverflow <= 1'b0;
        settle();
        chk(32'(statusFlags.chanEventFlag), 32'h3);
        // input mode: software and pin captures
        wr(tevt_pkg::CTRL_OFFSET, 32'h000003C0);
        wr(tevt_pkg::STATUS_OFFSET, 32'h0);
        counterValue <= 16'hABCD;
        ev(32'h00000002);
        chk(32'({statusFlags.chanOvercaptureFlag[0], statusFlags.chanEventFlag[0]}), 32'h1);
        ev(32'h00000002);
        chk(32'(statusFlags.chanOvercaptureFlag[0]), 32'h1);
        rd(tevt_pkg::COMPARE_BASE, 32'h0000ABCD);
        settle();
        chk(32'(statusFlags.chanEventFlag[0]), 32'h0);
        @(posedge ref_clk);
        counterValue <= 16'h0055;
        chanInputSignal <= 4'h4;
        for (int n = 0; n < 10 && statusFlags.chanEventFlag[2] !== 1'b1; n++)
            @(posedge ref_clk);
        #1;
        chk(32'(statusFlags.chanEventFlag[2]), 32'h1);
        if (statusFlags.chanEventFlag[2] !== 1'b1)
            conclude();
        rd(8'h3C, 32'h00000055);
        // channel 4 on falling edges: a rising edge must be ignored
        wr(tevt_pkg::CTRL_OFFSET, 32'h000023C0);
        counterValue <= 16'h0066;
        chanInputSignal <= 4'hC;
        settle();
        chk(32'(statusFlags.chanEventFlag[3]), 32'h0);
        @(posedge ref_clk);
        chanInputSignal <= 4'h4;
        settle();
        chk(32'(statusFlags.chanEventFlag[3]), 32'h1);
        rd(8'h40, 32'h00000066);
        // repetition zero and trigger reinit, allowed then blocked
        for (int i = 0; i < 4; i++)
        begin
            wr(tevt_pkg::CTRL_OFFSET, (i < 2) ? 32'h0 : ((i == 2) ? 32'h8 : 32'h10));
            wr(tevt_pkg::STATUS_OFFSET, 32'h0);
            repetitionZero <= ~i[0];
            triggerReinit <= i[0];
            @(posedge ref_clk);
            repetitionZero <= 1'b0;
            triggerReinit <= 1'b0;
            settle();
            chk(32'(statusFlags.updateFlag), (i < 2) ? 32'h1 : 32'h0);
        end
        conclude();
    end
endmodule
`default_nettype wire

// ### test/timer_event_generation_checker.sv
// concurrent checks on the ports of the timer event generation block
`timescale 1ns/1ps
`default_nettype none
module timer_event_generation_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [tevt_pkg::ADDR_W-1:0] regAddr,
    input wire logic [tevt_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [tevt_pkg::DATA_W-1:0] regRdata,
    // events and flags
    input wire logic counterReinit,
    input wire logic prescalerClear,
    input wire logic updateEvent,
    input wire logic triggerEvent,
    input wire logic breakEvent,
    input wire logic commutationEvent,
    input wire logic mainOutputEnable,
    input wire tevt_pkg::status_t statusFlags
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    wire evtWrite = regWrite && (regAddr == tevt_pkg::EVTGEN_OFFSET);
    wire trigWrite = evtWrite && regWdata[tevt_pkg::EVT_TRIG_BIT];

    chk_update_reinit: assert property (evtWrite && regWdata[0] |-> ##2 counterReinit && prescalerClear)
        else $error("update request did not reinit counter and prescaler");
    chk_trigger_flag: assert property (trigWrite |-> ##2 triggerEvent && statusFlags.triggerFlag)
        else $error("trigger request without trigger strobe and flag");
    chk_trigger_cause: assert property ($rose(triggerEvent) |-> $past(trigWrite, 2))
        else $error("trigger strobe without a request");
    chk_break_output: assert property (evtWrite && regWdata[7]
        |-> ##2 breakEvent && statusFlags.breakFlag && !mainOutputEnable)
        else $error("break request did not drop output enable and set flag");
    chk_comm_event: assert property (evtWrite && regWdata[5] |-> ##2 commutationEvent)
        else $error("commutation request without strobe");
    chk_zero_write: assert property (evtWrite && regWdata[7:0] == 8'h00
        |-> ##2 !(counterReinit || triggerEvent || breakEvent || commutationEvent))
        else $error("zero write raised an event");
    chk_evt_readback: assert property (regRead && regAddr == tevt_pkg::EVTGEN_OFFSET
        |=> regRdata == 32'h00000000)
        else $error("event generation register read not zero");
    chk_update_flag: assert property ($rose(statusFlags.updateFlag) |-> updateEvent)
        else $error("update flag set without update strobe");
    chk_overcapture: assert property ($rose(statusFlags.chanOvercaptureFlag[0])
        |-> $past(statusFlags.chanEventFlag[0]))
        else $error("overcapture set while flag was clear");
endmodule
`default_nettype wire
